/* File: common/cmp_skip_pkg.sv */
`default_nettype none
package cmp_skip_pkg;

    localparam int          DATA_WIDTH   = 8;
    localparam int          PC_WIDTH     = 16;
    localparam int          OFFSET_WIDTH = 7;

    // Status flag bit positions
    localparam logic [2:0]  FLAG_C_POS   = 3'h0;
    localparam logic [2:0]  FLAG_Z_POS   = 3'h1;
    localparam logic [2:0]  FLAG_N_POS   = 3'h2;
    localparam logic [2:0]  FLAG_V_POS   = 3'h3;
    localparam logic [2:0]  FLAG_H_POS   = 3'h5;

    // Reset values
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [1:0]  REMAIN_RESET = 2'h0;

    // Program counter steps in words
    localparam logic [1:0]  PC_STEP_NEXT     = 2'h1;
    localparam logic [1:0]  PC_STEP_SKIP_ONE = 2'h2;
    localparam logic [1:0]  PC_STEP_SKIP_TWO = 2'h3;

    // Cycle counts
    localparam logic [1:0]  CYCLES_SHORT        = 2'h1;
    localparam logic [1:0]  CYCLES_BRANCH_TAKEN = 2'h2;
    localparam logic [1:0]  CYCLES_SKIP_ONE     = 2'h2;
    localparam logic [1:0]  CYCLES_SKIP_TWO     = 2'h3;

    typedef enum logic [3:0] {
        compare_immediate_op,
        skip_reg_bit_clear_op,
        skip_reg_bit_set_op,
        skip_io_bit_clear_op,
        skip_io_bit_set_op,
        branch_flag_set_op,
        branch_flag_clear_op,
        branch_carry_clear_op,
        branch_unsigned_ge_op
    } op_t;

    // Bit of a byte chosen by a 3-bit index
    function automatic logic pick_bit(input logic [7:0] value, input logic [2:0] sel);
        pick_bit = value[sel];
    endfunction : pick_bit

endpackage : cmp_skip_pkg
`default_nettype wire

/* File: common/cmp_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cmp_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] flags_in;
    logic [7:0] flags_out;

    modport alu  (input minuend, input subtrahend, input flags_in, output flags_out);
    modport user (output minuend, output subtrahend, output flags_in, input flags_out);
endinterface : cmp_if
`default_nettype wire

/* File: hdl/compare_flags.sv */
`timescale 1ns/1ns
`default_nettype none
module compare_flags
    import cmp_skip_pkg::*;
(
    cmp_if.alu cmp
);

    logic [7:0] diff;
    logic [7:0] a;
    logic [7:0] b;
    logic       h_flag;
    logic       v_flag;
    logic       c_flag;

    assign a      = cmp.minuend;
    assign b      = cmp.subtrahend;
    assign diff   = a - b;
    // Borrow out of bit 3 and bit 7
    assign h_flag = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
    assign c_flag = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
    assign v_flag = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);

    // Difference itself is dropped, only flags leave
    always_comb begin
        cmp.flags_out             = cmp.flags_in;
        cmp.flags_out[FLAG_Z_POS] = (diff == 8'h00);
        cmp.flags_out[FLAG_N_POS] = diff[7];
        cmp.flags_out[FLAG_V_POS] = v_flag;
        cmp.flags_out[FLAG_C_POS] = c_flag;
        cmp.flags_out[FLAG_H_POS] = h_flag;
    end

endmodule : compare_flags
`default_nettype wire

/* File: hdl/compare_skip_branch_unit.sv */
// Overview of operation
// - Compare-with-immediate sets Z, N, V, C and H from register minus constant, drops the difference, one cycle.
// - Register-bit-clear skip moves the PC past the next instruction (plus 2 or 3) when the bit is zero.
// - Register-bit-set skip moves the PC on by 2 or 3 when the bit is one, else to the next instruction.
// - I/O-bit-clear skip adds 2 or 3 to the PC when the I/O bit reads zero, flags untouched.
// - I/O-bit-set skip adds 2 or 3 to the PC when the I/O bit reads one, flags untouched.
// - Flag-set branch loads PC plus offset plus one when the chosen status bit is one, taking one or two cycles.
// - Flag-clear branch loads PC plus offset plus one when the chosen status bit is zero, flags untouched.
// - Carry-clear branch is taken to PC plus offset plus one only while carry is zero.
// - Unsigned same-or-higher branch behaves as the carry-clear test and changes no flag.
`timescale 1ns/1ns
`default_nettype none
module compare_skip_branch_unit
    import cmp_skip_pkg::*;
#(
    parameter int PC_W = PC_WIDTH
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_issue_valid,
    output logic                         o_issue_ready,
    input  wire op_t                     i_op,
    input  wire logic [DATA_WIDTH-1:0]   i_reg_value,
    input  wire logic [DATA_WIDTH-1:0]   i_imm_value,
    input  wire logic [2:0]              i_bit_sel,
    input  wire logic [DATA_WIDTH-1:0]   i_io_value,
    input  wire logic [OFFSET_WIDTH-1:0] i_offset,
    input  wire logic [PC_W-1:0]         i_pc,
    input  wire logic                    i_next_two_word,
    input  wire logic [7:0]              i_status_flags_register,
    output logic                         o_done,
    output logic                         o_pc_load,
    output logic [PC_W-1:0]              o_pc_value,
    output logic                         o_flags_we,
    output logic [7:0]                   o_status_flags_register
);

    typedef enum logic {ST_IDLE, ST_WAIT} state_t;

    state_t          state_reg;
    state_t          state_next;
    logic [1:0]      remain_reg;
    logic [1:0]      remain_next;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic            done_reg;
    logic            done_next;
    logic            flags_we_reg;
    logic            flags_we_next;
    logic [7:0]      flags_reg;
    logic [7:0]      flags_next;

    cmp_if cmp_bus ();

    compare_flags u_compare_flags (
        .cmp (cmp_bus.alu)
    );

    // Decode
    wire accept       = i_issue_valid && (state_reg == ST_IDLE);
    wire is_cmp       = (i_op == compare_immediate_op);
    wire reg_bit      = pick_bit(i_reg_value, i_bit_sel);
    wire io_bit       = pick_bit(i_io_value, i_bit_sel);
    wire flag_bit     = pick_bit(i_status_flags_register, i_bit_sel);
    wire carry        = i_status_flags_register[FLAG_C_POS];

    wire skip_rc      = (i_op == skip_reg_bit_clear_op) && !reg_bit;
    wire skip_rs      = (i_op == skip_reg_bit_set_op) && reg_bit;
    wire skip_ic      = (i_op == skip_io_bit_clear_op) && !io_bit;
    wire skip_is      = (i_op == skip_io_bit_set_op) && io_bit;
    wire skip_hit     = skip_rc || skip_rs || skip_ic || skip_is;

    wire br_fs        = (i_op == branch_flag_set_op) && flag_bit;
    wire br_fc        = (i_op == branch_flag_clear_op) && !flag_bit;
    wire br_cc        = (i_op == branch_carry_clear_op) && !carry;
    wire br_ge        = (i_op == branch_unsigned_ge_op) && !carry;
    wire branch_hit   = br_fs || br_fc || br_cc || br_ge;

    // Sign-extended word offset
    wire [PC_W-1:0] offset_ext  = PC_W'($signed(i_offset));
    wire [1:0]      skip_step   = i_next_two_word ? PC_STEP_SKIP_TWO : PC_STEP_SKIP_ONE;
    wire [1:0]      skip_cycles = i_next_two_word ? CYCLES_SKIP_TWO : CYCLES_SKIP_ONE;
    wire [PC_W-1:0] pc_seq      = i_pc + PC_W'(PC_STEP_NEXT);
    wire [PC_W-1:0] pc_skip     = i_pc + PC_W'(skip_step);
    wire [PC_W-1:0] pc_branch   = i_pc + offset_ext + PC_W'(PC_STEP_NEXT);

    wire [PC_W-1:0] pc_result   = branch_hit ? pc_branch :
                                  skip_hit   ? pc_skip   : pc_seq;
    wire [1:0]      cycles      = branch_hit ? CYCLES_BRANCH_TAKEN :
                                  skip_hit   ? skip_cycles : CYCLES_SHORT;

    assign cmp_bus.minuend    = i_reg_value;
    assign cmp_bus.subtrahend = i_imm_value;
    assign cmp_bus.flags_in   = i_status_flags_register;

    // Next state
    always_comb begin
        state_next    = state_reg;
        remain_next   = remain_reg;
        pc_next       = pc_reg;
        done_next     = 1'b0;
        flags_we_next = 1'b0;
        flags_next    = flags_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    pc_next = pc_result;
                    if (is_cmp) begin
                        flags_next    = cmp_bus.flags_out;
                        flags_we_next = 1'b1;
                    end
                    if (cycles == CYCLES_SHORT) begin
                        done_next = 1'b1;
                    end else begin
                        state_next  = ST_WAIT;
                        remain_next = cycles - 2'h1;
                    end
                end
            end
            ST_WAIT: begin
                remain_next = remain_reg - 2'h1;
                if (remain_reg == 2'h1) begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_reg    <= ST_IDLE;
            remain_reg   <= REMAIN_RESET;
            pc_reg       <= '0;
            done_reg     <= 1'b0;
            flags_we_reg <= 1'b0;
            flags_reg    <= FLAGS_RESET;
        end else begin
            state_reg    <= state_next;
            remain_reg   <= remain_next;
            pc_reg       <= pc_next;
            done_reg     <= done_next;
            flags_we_reg <= flags_we_next;
            flags_reg    <= flags_next;
        end
    end

    assign o_issue_ready           = (state_reg == ST_IDLE);
    assign o_done                  = done_reg;
    assign o_pc_load               = done_reg;
    assign o_pc_value              = pc_reg;
    assign o_flags_we              = flags_we_reg;
    assign o_status_flags_register = flags_reg;

    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_cmp_one_cycle;
        (accept && is_cmp) |=> o_done && o_flags_we
            && (o_status_flags_register[FLAG_Z_POS] == ($past(i_reg_value) == $past(i_imm_value)))
            && (o_status_flags_register[FLAG_C_POS] == ($past(i_reg_value) < $past(i_imm_value)))
            && (o_pc_value == $past(i_pc) + PC_W'(PC_STEP_NEXT));
    endproperty
    a_cmp_one_cycle: assert property (p_cmp_one_cycle) else $error("compare result wrong");

    property p_skip_reg_clear;
        (accept && i_op == skip_reg_bit_clear_op && !i_reg_value[i_bit_sel] && !i_next_two_word)
            |=> !o_done ##1 o_done && !o_flags_we && o_pc_value == $past(i_pc, 2) + PC_W'(PC_STEP_SKIP_ONE);
    endproperty
    a_skip_reg_clear: assert property (p_skip_reg_clear) else $error("register clear skip wrong");

    property p_skip_reg_set;
        (accept && i_op == skip_reg_bit_set_op && i_reg_value[i_bit_sel] && i_next_two_word)
            |=> !o_done [*2] ##1 o_done && o_pc_value == $past(i_pc, 3) + PC_W'(PC_STEP_SKIP_TWO);
    endproperty
    a_skip_reg_set: assert property (p_skip_reg_set) else $error("register set skip wrong");

    property p_skip_io_clear_miss;
        (accept && i_op == skip_io_bit_clear_op && i_io_value[i_bit_sel])
            |=> o_done && !o_flags_we && o_pc_value == $past(i_pc) + PC_W'(PC_STEP_NEXT);
    endproperty
    a_skip_io_clear_miss: assert property (p_skip_io_clear_miss) else $error("io clear skip wrong");

    property p_skip_io_set;
        (accept && i_op == skip_io_bit_set_op && i_io_value[i_bit_sel] && !i_next_two_word)
            |=> !o_done ##1 o_done && !o_flags_we && o_pc_value == $past(i_pc, 2) + PC_W'(PC_STEP_SKIP_ONE);
    endproperty
    a_skip_io_set: assert property (p_skip_io_set) else $error("io set skip wrong");

    property p_branch_flag_set;
        (accept && i_op == branch_flag_set_op && i_status_flags_register[i_bit_sel])
            |=> !o_done ##1 o_done && !o_flags_we
                && o_pc_value == $past(i_pc, 2) + PC_W'(PC_STEP_NEXT)
                   + {{(PC_W-OFFSET_WIDTH){$past(i_offset[OFFSET_WIDTH-1], 2)}}, $past(i_offset, 2)};
    endproperty
    a_branch_flag_set: assert property (p_branch_flag_set) else $error("flag set branch wrong");

    property p_branch_flag_clear_miss;
        (accept && i_op == branch_flag_clear_op && i_status_flags_register[i_bit_sel])
            |=> o_done && !o_flags_we && o_pc_value == $past(i_pc) + PC_W'(PC_STEP_NEXT);
    endproperty
    a_branch_flag_clear_miss: assert property (p_branch_flag_clear_miss) else $error("flag clear wrong");

    property p_branch_carry_clear;
        (accept && i_op == branch_carry_clear_op && !i_status_flags_register[FLAG_C_POS])
            |=> !o_done && !o_issue_ready ##1 o_pc_load && !o_flags_we;
    endproperty
    a_branch_carry_clear: assert property (p_branch_carry_clear) else $error("carry branch wrong");

    property p_branch_ge_miss;
        (accept && i_op == branch_unsigned_ge_op && i_status_flags_register[FLAG_C_POS])
            |=> o_done && !o_flags_we && o_pc_value == $past(i_pc) + PC_W'(PC_STEP_NEXT);
    endproperty
    a_branch_ge_miss: assert property (p_branch_ge_miss) else $error("same or higher wrong");

    property p_offset_signed;
        (accept && branch_hit && i_offset[OFFSET_WIDTH-1])
            |=> ##1 o_done && (o_pc_value == $past(i_pc, 2) - PC_W'(7'h7F - $past(i_offset, 2)));
    endproperty
    a_offset_signed: assert property (p_offset_signed) else $error("negative offset wrong");

    c_cmp:          cover property (accept && is_cmp);
    c_skip_two:     cover property (accept && skip_hit && i_next_two_word);
    c_branch_taken: cover property (accept && branch_hit);
    c_back_to_back: cover property (o_done && accept);

endmodule : compare_skip_branch_unit
`default_nettype wire

/* File: tb/compare_skip_branch_unit_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module compare_skip_branch_unit_test import cmp_skip_pkg::*;;
    logic        i_sys_clk;
    logic        i_resetn;
    logic        i_issue_valid;
    logic        o_issue_ready;
    op_t         i_op;
    logic [7:0]  i_reg_value;
    logic [7:0]  i_imm_value;
    logic [2:0]  i_bit_sel;
    logic [7:0]  i_io_value;
    logic [6:0]  i_offset;
    logic [15:0] i_pc;
    logic        i_next_two_word;
    logic [7:0]  i_status_flags_register;
    logic        o_done;
    logic        o_pc_load;
    logic [15:0] o_pc_value;
    logic        o_flags_we;
    logic [7:0]  o_status_flags_register;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [7:0]  last_fl = 8'h00;

    compare_skip_branch_unit u_compare_skip_branch_unit (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_issue_valid(i_issue_valid), .o_issue_ready(o_issue_ready), .i_op(i_op), .i_reg_value(i_reg_value),
        .i_imm_value(i_imm_value), .i_bit_sel(i_bit_sel), .i_io_value(i_io_value), .i_offset(i_offset),
        .i_pc(i_pc), .i_next_two_word(i_next_two_word), .i_status_flags_register(i_status_flags_register),
        .o_done(o_done), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_flags_we(o_flags_we),
        .o_status_flags_register(o_status_flags_register));

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // One instruction: offer, accept, time the completion, judge results
    task automatic issue(input op_t op, input logic [7:0] rv, input logic [7:0] iv, input logic [2:0] bs,
                         input logic [7:0] io, input logic [6:0] off, input logic [15:0] pc, input logic two,
                         input logic [7:0] fl, input logic [15:0] e_pc, input int e_n, input logic e_we);
        int n;
        n = 0;
        `CHK("ready", 1'b1, o_issue_ready)
        i_issue_valid = 1'b1;
        i_op = op;
        i_reg_value = rv;
        i_imm_value = iv;
        i_bit_sel = bs;
        i_io_value = io;
        i_offset = off;
        i_pc = pc;
        i_next_two_word = two;
        i_status_flags_register = fl;
        @(negedge i_sys_clk);
        i_issue_valid = 1'b0;
        i_status_flags_register = ~fl;
        while (o_done !== 1'b1 && n < 4) begin
            `CHK("busy_ready", 1'b0, o_issue_ready)
            n++;
            @(negedge i_sys_clk);
        end
        n++;
        `CHK("cycles", e_n, n)
        `CHK("pc_load", 1'b1, o_pc_load)
        `CHK("done_ready", 1'b1, o_issue_ready)
        `CHK("pc_value", e_pc, o_pc_value)
        `CHK("flags_we", e_we, o_flags_we)
        `CHK("flags", last_fl, o_status_flags_register)
        @(negedge i_sys_clk);
        `CHK("done_pulse", 1'b0, o_done)
    endtask : issue

    task automatic test_reset();
        `CHK("rst_ready", 1'b1, o_issue_ready)
        `CHK("rst_done", 1'b0, o_done)
        `CHK("rst_pc", 16'h0000, o_pc_value)
        `CHK("rst_flags", FLAGS_RESET, o_status_flags_register)
    endtask : test_reset

    task automatic test_compare();
        logic [7:0] rd [5] = '{8'h00, 8'h80, 8'h10, 8'h5A, 8'h7F};
        logic [7:0] k  [5] = '{8'h01, 8'h01, 8'h01, 8'h5A, 8'hFF};
        logic [7:0] r;
        for (int i = 0; i < 5; i++) begin
            r = rd[i] - k[i];
            last_fl = 8'hD0;
            last_fl[FLAG_C_POS] = rd[i] < k[i];
            last_fl[FLAG_Z_POS] = r == 8'h00;
            last_fl[FLAG_N_POS] = r[7];
            last_fl[FLAG_V_POS] = (rd[i][7] != k[i][7]) && (r[7] != rd[i][7]);
            last_fl[FLAG_H_POS] = rd[i][3:0] < k[i][3:0];
            issue(compare_immediate_op, rd[i], k[i], 3'h0, 8'h00, 7'h00, 16'h0100, 1'b0, 8'hD0,
                  16'h0101, 1, 1'b1);
        end
    endtask : test_compare

    task automatic test_skips();
        logic [7:0] m;
        logic       v;
        logic       tw;
        logic [15:0] pc;
        for (int i = 0; i < 4; i++) begin
            v = i[0];
            tw = i[1];
            m = 8'h01 << (i * 2 + 1);
            pc = (i == 3) ? 16'hFFFF : 16'h0200;
            issue(skip_reg_bit_clear_op, v ? m : ~m, 8'h00, 3'(i * 2 + 1), v ? ~m : m, 7'h00, pc, tw, 8'h00,
                  v ? pc + 16'h1 : pc + 16'h2 + tw, v ? 1 : 2 + tw, 1'b0);
            issue(skip_reg_bit_set_op, v ? m : ~m, 8'h00, 3'(i * 2 + 1), v ? ~m : m, 7'h00, pc, tw, 8'h00,
                  v ? pc + 16'h2 + tw : pc + 16'h1, v ? 2 + tw : 1, 1'b0);
            issue(skip_io_bit_clear_op, v ? ~m : m, 8'h00, 3'(i * 2 + 1), v ? m : ~m, 7'h00, pc, tw, 8'hFF,
                  v ? pc + 16'h1 : pc + 16'h2 + tw, v ? 1 : 2 + tw, 1'b0);
            issue(skip_io_bit_set_op, v ? ~m : m, 8'h00, 3'(i * 2 + 1), v ? m : ~m, 7'h00, pc, tw, 8'hFF,
                  v ? pc + 16'h2 + tw : pc + 16'h1, v ? 2 + tw : 1, 1'b0);
        end
    endtask : test_skips

    task automatic test_flag_branches();
        logic [7:0]  m;
        logic [6:0]  off;
        logic [15:0] tgt;
        for (int s = 0; s < 16; s++) begin
            m = 8'h01 << s[2:0];
            off = s[3] ? 7'h40 : 7'h3F;
            tgt = 16'h1000 + {{9{off[6]}}, off} + 16'h1;
            issue(branch_flag_set_op, 8'h00, 8'h00, s[2:0], 8'h00, off, 16'h1000, 1'b0, s[3] ? m : ~m,
                  s[3] ? tgt : 16'h1001, s[3] ? 2 : 1, 1'b0);
            issue(branch_flag_clear_op, 8'h00, 8'h00, s[2:0], 8'h00, off, 16'h1000, 1'b0, s[3] ? ~m : m,
                  s[3] ? tgt : 16'h1001, s[3] ? 2 : 1, 1'b0);
        end
    endtask : test_flag_branches

    task automatic test_carry_branches();
        for (int c = 0; c < 2; c++) begin
            issue(branch_carry_clear_op, 8'h00, 8'h00, 3'h0, 8'h00, 7'h7E, 16'h0010, 1'b0, c ? 8'h01 : 8'hFE,
                  c ? 16'h0011 : 16'h000F, c ? 1 : 2, 1'b0);
            issue(branch_unsigned_ge_op, 8'h00, 8'h00, 3'h5, 8'h00, 7'h05, 16'h0010, 1'b0, c ? 8'h01 : 8'hFE,
                  c ? 16'h0011 : 16'h0016, c ? 1 : 2, 1'b0);
        end
    endtask : test_carry_branches

    // Second request held across the busy cycle, taken in the done cycle
    task automatic test_back_to_back();
        i_issue_valid = 1'b1;
        i_op = branch_carry_clear_op;
        i_offset = 7'h03;
        i_pc = 16'h0300;
        i_status_flags_register = 8'h00;
        @(negedge i_sys_clk);
        `CHK("b2b_busy", 1'b0, o_issue_ready)
        i_op = compare_immediate_op;
        i_reg_value = 8'h22;
        i_imm_value = 8'h22;
        i_pc = 16'h0400;
        @(negedge i_sys_clk);
        `CHK("b2b_done", 1'b1, o_pc_load)
        `CHK("b2b_ready", 1'b1, o_issue_ready)
        `CHK("b2b_pc", 16'h0304, o_pc_value)
        @(negedge i_sys_clk);
        i_issue_valid = 1'b0;
        last_fl = 8'h02;
        `CHK("b2b_cmp_done", 1'b1, o_done)
        `CHK("b2b_cmp_pc", 16'h0401, o_pc_value)
        `CHK("b2b_cmp_flags", last_fl, o_status_flags_register)
        @(negedge i_sys_clk);
        `CHK("b2b_idle", 1'b0, o_done)
    endtask : test_back_to_back

    initial begin
        i_resetn = 1'b0;
        i_issue_valid = 1'b0;
        i_op = compare_immediate_op;
        i_reg_value = 8'h00;
        i_imm_value = 8'h00;
        i_bit_sel = 3'h0;
        i_io_value = 8'h00;
        i_offset = 7'h00;
        i_pc = 16'h0000;
        i_next_two_word = 1'b0;
        i_status_flags_register = 8'h00;
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        test_reset();
        i_resetn = 1'b1;
        test_compare();
        test_skips();
        test_flag_branches();
        test_carry_branches();
        test_back_to_back();
        tally_and_finish();
    end
endmodule : compare_skip_branch_unit_test
`default_nettype wire
